// [common/spims_pkg.sv]
// Purpose: constants for the SPI shifter
// Assumes: 20 MHz mclk_i
// Notes:   link clock is oversampled by mclk_i
`default_nettype none
package spims_pkg;
	localparam int unsigned CHAR_W      = 8;
	localparam int unsigned CNT_W       = 4;
	localparam logic [3:0]  LEN7        = 4'h7;
	localparam logic [3:0]  LEN8        = 4'h8;
	localparam logic [1:0]  GAP_CYCLES  = 2'h2;
	localparam logic [7:0]  RX_RESET    = 8'h00;
	typedef enum logic [1:0] {
		SPIMS_IDLE  = 2'b00,
		SPIMS_FIRST = 2'b01,
		SPIMS_SECND = 2'b11,
		SPIMS_GAP   = 2'b10
	} spims_state_e;
endpackage : spims_pkg
`default_nettype wire

// [hdl/spims_shifter.sv]
// Purpose: SPI master/slave shifter with double buffered paths
// Assumes: pins sampled by mclk_i; baud tick from shared generator
// Notes:   two-entry transmit buffer with valid/ready
`default_nettype none
module spims_shifter #(
	parameter int unsigned DEPTH = 2
) (
	input  wire logic       mclk_i,
	input  wire logic       reset_i,
	input  wire logic       sync_mode_i,
	input  wire logic       master_select_bit_i,
	input  wire logic       four_pin_i,
	input  wire logic       char8_i,
	input  wire logic       clk_polarity_i,
	input  wire logic       port_function_select_i,
	input  wire logic       baud_tick_i,
	input  wire logic       tx_valid_i,
	input  wire logic [7:0] tx_data_i,
	output logic            tx_ready_o,
	output logic            rx_valid_o,
	input  wire logic       rx_ready_i,
	output logic [7:0]      receive_buffer_o,
	output logic            receive_flag_o,
	output logic            transmit_ready_flag_o,
	input  wire logic       rx_int_ack_i,
	input  wire logic       tx_int_ack_i,
	output logic            overrun_error_o,
	output logic            bus_conflict_error_bit_o,
	input  wire logic       error_clear_i,
	input  wire logic       serial_clock_pin_i,
	output logic            serial_clock_pin_o,
	output logic            serial_clock_pin_oe_n_o,
	input  wire logic       master_out_data_pin_i,
	output logic            master_out_data_pin_o,
	output logic            master_out_data_pin_oe_n_o,
	input  wire logic       master_in_data_pin_i,
	output logic            master_in_data_pin_o,
	output logic            master_in_data_pin_oe_n_o,
	input  wire logic       slave_transmit_enable_pin_i
);
	// Pin synchronisers: first stage read only by second stage
	logic [3:0] sync1, sync2;
	logic       sclk_d;
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			// Reset to polarity 0 idle pin levels (clock low), so no false clock edge follows reset while clk_polarity_i is 0
			sync1  <= 4'h8;
			sync2  <= 4'h8;
			sclk_d <= 1'b0;
		end else begin
			sync1  <= {slave_transmit_enable_pin_i, serial_clock_pin_i, master_out_data_pin_i, master_in_data_pin_i};
			sync2  <= sync1;
			sclk_d <= sync2[2];
		end
	end
	wire ste_s  = sync2[3];
	wire sclk_s = sync2[2];
	wire mosi_s = sync2[1];
	wire miso_s = sync2[0];

	// Transmit buffer: two entries, ready reaches the software side
	logic [7:0]      tbuf [DEPTH];
	logic [1:0]      tcount, next_tcount;
	logic            twr, next_twr, trd, next_trd;
	wire             tpop;
	wire             tpush = tx_valid_i && tx_ready_o;
	assign tx_ready_o = (tcount != 2'(DEPTH));
	wire   tbuf_valid = (tcount != 2'h0);
	always_comb begin
		next_tcount = 2'(tcount + {1'b0, tpush} - {1'b0, tpop});
		next_twr    = tpush ? ~twr : twr;
		next_trd    = tpop ? ~trd : trd;
	end
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			tcount <= 2'h0;
			twr    <= 1'b0;
			trd    <= 1'b0;
		end else begin
			tcount <= next_tcount;
			twr    <= next_twr;
			trd    <= next_trd;
			if (tpush)
				tbuf[twr] <= tx_data_i;
		end
	end

	// Shifter core
	spims_pkg::spims_state_e state, next_state;
	logic [7:0] tsh, next_tsh, rsh, next_rsh, rbuf, next_rbuf;
	logic [3:0] bitn, next_bitn;
	logic [1:0] gap, next_gap;
	logic       sck, next_sck, rflag, next_rflag, tflag, next_tflag;
	logic       ovr, next_ovr, fe, next_fe, rfull, next_rfull, tsh_full, next_tsh_full;

	wire master  = master_select_bit_i;
	wire ste_use = four_pin_i && port_function_select_i;
	wire m_block = master && ste_use && !ste_s;
	wire s_en    = !ste_use || !ste_s;
	wire [3:0] len = char8_i ? spims_pkg::LEN8 : spims_pkg::LEN7;
	wire s_lead  = sclk_s && !sclk_d;
	wire s_trail = !sclk_s && sclk_d;
	wire s_cap   = clk_polarity_i ? s_trail : s_lead;
	wire s_shift = clk_polarity_i ? s_lead : s_trail;
	assign tpop  = tbuf_valid && !tsh_full && sync_mode_i && !m_block && state == spims_pkg::SPIMS_IDLE;
	wire rd      = rx_valid_o && rx_ready_i;

	always_comb begin
		next_state    = state;
		next_tsh      = tsh;
		next_rsh      = rsh;
		next_rbuf     = rbuf;
		next_bitn     = bitn;
		next_gap      = gap;
		next_sck      = sck;
		next_tsh_full = tsh_full;
		next_rfull    = rfull;
		next_ovr      = error_clear_i ? 1'b0 : ovr;
		next_fe       = error_clear_i ? 1'b0 : fe;
		next_rflag    = (rd || rx_int_ack_i) ? 1'b0 : rflag;
		next_tflag    = (tpush || tx_int_ack_i) ? 1'b0 : tflag;
		if (rd)
			next_rfull = 1'b0;
		if (tpop) begin
			// Bit 7 always leads; a 7-bit character is its top seven bits
			next_tsh      = tbuf[trd];
			next_tsh_full = 1'b1;
			next_bitn     = 4'h0;
			next_rsh      = spims_pkg::RX_RESET;
			if (master) begin
				next_state = spims_pkg::SPIMS_FIRST;
				next_sck   = 1'b0;
			end
		end
		if (!sync_mode_i) begin
			next_state    = spims_pkg::SPIMS_IDLE;
			next_sck      = 1'b0;
		end else if (master) begin
			if (m_block) begin
				next_fe    = 1'b1;
				next_rflag = 1'b1;
			end else if (baud_tick_i) begin
				unique case (state)
					spims_pkg::SPIMS_IDLE: ;
					spims_pkg::SPIMS_FIRST: begin
						next_sck   = 1'b1;
						next_rsh   = {rsh[6:0], miso_s};
						next_state = spims_pkg::SPIMS_SECND;
					end
					spims_pkg::SPIMS_SECND: begin
						next_sck  = 1'b0;
						next_tsh  = {tsh[6:0], 1'b0};
						next_bitn = 4'(bitn + 4'h1);
						next_state = (4'(bitn + 4'h1) == len) ? spims_pkg::SPIMS_GAP : spims_pkg::SPIMS_FIRST;
						next_gap  = 2'h0;
					end
					spims_pkg::SPIMS_GAP: begin
						next_gap = 2'(gap + 2'h1);
						if (2'(gap + 2'h1) == spims_pkg::GAP_CYCLES) begin
							next_state    = spims_pkg::SPIMS_IDLE;
							next_tsh_full = 1'b0;
						end
					end
				endcase
			end
			if (state == spims_pkg::SPIMS_GAP && gap == 2'h0 && baud_tick_i && !m_block) begin
				next_rbuf  = char8_i ? rsh : {1'b0, rsh[6:0]};
				next_rflag = 1'b1;
				next_rfull = 1'b1;
				next_ovr   = ovr || (rfull && !rd);
			end
		end else if (s_en) begin
			if (s_cap) begin
				next_rsh  = {rsh[6:0], mosi_s};
				next_bitn = 4'(bitn + 4'h1);
				if (4'(bitn + 4'h1) == len) begin
					next_rbuf     = char8_i ? {rsh[6:0], mosi_s} : {1'b0, rsh[5:0], mosi_s};
					next_rflag    = 1'b1;
					next_rfull    = 1'b1;
					next_ovr      = ovr || (rfull && !rd);
					next_bitn     = 4'h0;
					next_tsh_full = 1'b0;
				end
			end else if (s_shift && bitn != 4'h0)
				next_tsh = {tsh[6:0], 1'b0};
		end
		if (!tsh_full && !tbuf_valid)
			next_tflag = 1'b1;
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			state    <= spims_pkg::SPIMS_IDLE;
			tsh      <= 8'h00;
			rsh      <= 8'h00;
			rbuf     <= spims_pkg::RX_RESET;
			bitn     <= 4'h0;
			gap      <= 2'h0;
			sck      <= 1'b0;
			rflag    <= 1'b0;
			tflag    <= 1'b1;
			ovr      <= 1'b0;
			fe       <= 1'b0;
			rfull    <= 1'b0;
			tsh_full <= 1'b0;
		end else begin
			state    <= next_state;
			tsh      <= next_tsh;
			rsh      <= next_rsh;
			rbuf     <= next_rbuf;
			bitn     <= next_bitn;
			gap      <= next_gap;
			sck      <= next_sck;
			rflag    <= next_rflag;
			tflag    <= next_tflag;
			ovr      <= next_ovr;
			fe       <= next_fe;
			rfull    <= next_rfull;
			tsh_full <= next_tsh_full;
		end
	end

	assign receive_buffer_o         = rbuf;
	assign rx_valid_o               = rfull;
	assign receive_flag_o           = rflag;
	assign transmit_ready_flag_o    = tflag;
	assign overrun_error_o          = ovr;
	assign bus_conflict_error_bit_o = fe;
	// Drive pins: idle clock level follows polarity
	assign serial_clock_pin_o         = sck ^ clk_polarity_i;
	assign serial_clock_pin_oe_n_o    = !(sync_mode_i && master && !m_block);
	assign master_out_data_pin_o      = tsh[7];
	assign master_out_data_pin_oe_n_o = !(sync_mode_i && master && !m_block);
	assign master_in_data_pin_o       = tsh[7];
	assign master_in_data_pin_oe_n_o  = !(sync_mode_i && !master && s_en);
endmodule : spims_shifter
`default_nettype wire

// [tb/spims_peer.sv]
// Purpose: behavioural far-side SPI device, slave or master
// Assumes: one common shift register, as a plain SPI peer has
// Notes:   its clock runs only inside frames and idles low
`default_nettype none
module spims_peer (
	input  wire logic sclk_i,
	input  wire logic din_i,
	output logic      sclk_o,
	output logic      dout_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] sr = 8'h00;
	logic       cap = 1'h0;
	initial sclk_o = 1'h0;
	assign dout_o = sr[7];
	always @(posedge sclk_i) cap <= din_i;
	// Shift on the falling edge so the far end samples a settled bit
	always @(negedge sclk_i) sr <= {sr[6:0], cap};
	task automatic clock_out(input int n);
		repeat (n) begin
			#200 sclk_o = 1'h1;
			#200 sclk_o = 1'h0;
		end
	endtask : clock_out
endmodule : spims_peer
`default_nettype wire

// [tb/spims_shifter_chk.sv]
// Purpose: port assertions for spims_shifter
// Assumes: pins pass two sync flops, so pin windows allow five cycles; the slave clock and off checks use three
// Notes:   bound to every spims_shifter instance
`default_nettype none
module spims_shifter_chk (
	input wire logic       mclk_i, reset_i, sync_mode_i, master_select_bit_i, four_pin_i, char8_i,
	input wire logic       port_function_select_i, slave_transmit_enable_pin_i, tx_ready_o, rx_valid_o,
	input wire logic       receive_flag_o, transmit_ready_flag_o, overrun_error_o, bus_conflict_error_bit_o,
	input wire logic       serial_clock_pin_oe_n_o, master_out_data_pin_oe_n_o, master_in_data_pin_oe_n_o,
	input wire logic [7:0] receive_buffer_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (reset_i);
	wire sel = slave_transmit_enable_pin_i;
	wire ck_off = serial_clock_pin_oe_n_o;
	wire mo_off = master_out_data_pin_oe_n_o;
	wire mi_off = master_in_data_pin_oe_n_o;
	wire m4 = sync_mode_i && master_select_bit_i && four_pin_i && port_function_select_i;
	chk_master_release: assert property ((m4 && !sel) [*5] |-> ck_off && mo_off)
		else $error("master pins not released");
	chk_conflict_report: assert property (m4 && $fell(sel) |-> ##[1:5] (bus_conflict_error_bit_o && receive_flag_o))
		else $error("conflict not reported");
	chk_master_drive: assert property ((sync_mode_i && master_select_bit_i && port_function_select_i
		&& (!four_pin_i || sel)) [*5] |-> !ck_off && !mo_off) else $error("master not driving");
	chk_slave_quiet: assert property ((sync_mode_i && !master_select_bit_i && four_pin_i && sel) [*5] |-> mi_off)
		else $error("deselected slave drives");
	chk_slave_clock: assert property ((sync_mode_i && !master_select_bit_i) [*3] |-> ck_off)
		else $error("slave drives clock");
	chk_short_msb: assert property (!char8_i && $rose(rx_valid_o) |-> !receive_buffer_o[7])
		else $error("short char top bit set");
	chk_overrun_cause: assert property ($rose(overrun_error_o) |-> $past(rx_valid_o))
		else $error("overrun without unread char");
	chk_full_flag: assert property (!tx_ready_o |-> !transmit_ready_flag_o)
		else $error("ready flag while buffer full");
	chk_off_idle: assert property ((!sync_mode_i) [*3] |-> ck_off && mi_off)
		else $error("pins driven while off");
endmodule : spims_shifter_chk
bind spims_shifter spims_shifter_chk chk (.*);
`default_nettype wire

// [tb/spims_shifter_test.sv]
// Purpose: self-checking bench for spims_shifter
// Assumes: baud tick every 8 cycles, peer clock period 400 ns
// Notes:   waits after writes follow the fixed bit and gap tick counts
`default_nettype none
module spims_shifter_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk_i = 1'h0, reset_i = 1'h1, sync_mode_i = 1'h1, master_select_bit_i = 1'h1, four_pin_i = 1'h0;
	logic char8_i = 1'h1, clk_polarity_i = 1'h0, port_function_select_i = 1'h1, baud_tick_i = 1'h0;
	logic tx_valid_i = 1'h0, rx_ready_i = 1'h0, rx_int_ack_i = 1'h0, tx_int_ack_i = 1'h0, error_clear_i = 1'h0;
	logic slave_transmit_enable_pin_i = 1'h1, p_sclk, p_dat, tx_ready_o, rx_valid_o, receive_flag_o;
	logic transmit_ready_flag_o, overrun_error_o, bus_conflict_error_bit_o, serial_clock_pin_o;
	logic serial_clock_pin_oe_n_o, master_out_data_pin_o, master_out_data_pin_oe_n_o;
	logic master_in_data_pin_o, master_in_data_pin_oe_n_o;
	logic [7:0] tx_data_i = 8'h00, receive_buffer_o, got;
	logic [2:0] bc = 3'h0;
	int fail_count = 0, tests_run = 0, cyc = 0;
	// A released data line shows the peer's moving shift bit and a released clock line p_sclk, never a held value
	wire serial_clock_pin_i = serial_clock_pin_oe_n_o ? p_sclk : serial_clock_pin_o;
	wire master_out_data_pin_i = master_out_data_pin_oe_n_o ? p_dat : master_out_data_pin_o;
	wire master_in_data_pin_i = master_in_data_pin_oe_n_o ? p_dat : master_in_data_pin_o;
	wire p_din = master_select_bit_i ? master_out_data_pin_i : master_in_data_pin_i;
	spims_shifter uut (.*);
	spims_peer peer (.sclk_i(serial_clock_pin_i), .din_i(p_din), .sclk_o(p_sclk), .dout_o(p_dat));
	always #25 mclk_i = !mclk_i;
	always @(negedge mclk_i) begin
		bc <= bc + 3'h1;
		baud_tick_i <= (bc == 3'h7);
	end
	always @(posedge mclk_i) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			fail_count++;
			complete_run();
		end
	end
	task automatic cmp(input logic [7:0] g, e, input string m);
		tests_run++;
		if (g !== e) begin
			fail_count++;
			$display("BAD %0t %s got %h", $time, m, g);
		end
	endtask : cmp
	task automatic idle(input int n);
		repeat (n) @(negedge mclk_i);
	endtask : idle
	task automatic put(input logic [7:0] d);
		@(negedge mclk_i);
		tx_valid_i = 1'h1;
		tx_data_i = d;
		while (tx_ready_o !== 1'h1) @(negedge mclk_i);
		@(negedge mclk_i);
		tx_valid_i = 1'h0;
	endtask : put
	task automatic take(output logic [7:0] d);
		@(negedge mclk_i);
		while (rx_valid_o !== 1'h1) @(negedge mclk_i);
		rx_ready_i = 1'h1;
		d = receive_buffer_o;
		@(negedge mclk_i);
		rx_ready_i = 1'h0;
	endtask : take
	task automatic pulse(ref logic s);
		@(negedge mclk_i);
		s = 1'h1;
		@(negedge mclk_i);
		s = 1'h0;
	endtask : pulse
	task automatic fin(input string s);
		$display("test %s done at %0t", s, $time);
	endtask : fin
	task automatic complete_run();
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : complete_run
	initial begin
		idle(8);
		reset_i = 1'h0;
		idle(2);
		cmp(transmit_ready_flag_o, 1'h1, "txf rst");
		cmp(receive_flag_o, 1'h0, "rxf rst");
		fin("reset");
		peer.sr = 8'h3c;
		put(8'ha5);
		put(8'h5a);
		put(8'hc3);
		cmp(tx_ready_o, 1'h0, "full");
		cmp(transmit_ready_flag_o, 1'h0, "txf wr");
		idle(3 * 18 * 8 + 32);
		cmp(overrun_error_o, 1'h1, "ovr");
		take(got);
		cmp(got, 8'h5a, "m rx");
		cmp(receive_flag_o, 1'h0, "rxf rd");
		cmp(peer.sr, 8'hc3, "p rx");
		fin("master8");
		char8_i = 1'h0;
		peer.sr = 8'h98;
		put(8'hb0);
		idle(18 * 8 + 32);
		pulse(rx_int_ack_i);
		cmp(receive_flag_o, 1'h0, "rxf ack");
		take(got);
		cmp(got, 8'h4c, "m rx7");
		cmp({1'h0, peer.sr[6:0]}, 8'h58, "p rx7");
		pulse(error_clear_i);
		cmp(overrun_error_o, 1'h0, "ovr clr");
		fin("master7");
		char8_i = 1'h1;
		four_pin_i = 1'h1;
		idle(8);
		slave_transmit_enable_pin_i = 1'h0;
		idle(8);
		cmp({bus_conflict_error_bit_o, receive_flag_o}, 8'h03, "conflict");
		cmp({serial_clock_pin_oe_n_o, master_out_data_pin_oe_n_o}, 8'h03, "release");
		slave_transmit_enable_pin_i = 1'h1;
		idle(8);
		cmp({serial_clock_pin_oe_n_o, master_out_data_pin_oe_n_o}, 8'h00, "restore");
		pulse(error_clear_i);
		pulse(rx_int_ack_i);
		four_pin_i = 1'h0;
		slave_transmit_enable_pin_i = 1'h0;
		idle(8);
		cmp({bus_conflict_error_bit_o, serial_clock_pin_oe_n_o}, 8'h00, "3pin");
		fin("conflict");
		master_select_bit_i = 1'h0;
		four_pin_i = 1'h1;
		slave_transmit_enable_pin_i = 1'h1;
		put(8'h54);
		peer.sr = 8'he8;
		idle(8);
		cmp({serial_clock_pin_oe_n_o, master_in_data_pin_oe_n_o}, 8'h03, "s idle");
		slave_transmit_enable_pin_i = 1'h0;
		idle(4);
		peer.clock_out(3);
		idle(4);
		slave_transmit_enable_pin_i = 1'h1;
		idle(8);
		cmp(master_in_data_pin_oe_n_o, 1'h1, "s pause");
		slave_transmit_enable_pin_i = 1'h0;
		idle(4);
		peer.clock_out(5);
		idle(4);
		take(got);
		cmp(got, 8'he8, "s rx");
		cmp(peer.sr, 8'h54, "s tx");
		fin("slave4");
		sync_mode_i = 1'h0;
		master_select_bit_i = 1'h1;
		put(8'h11);
		pulse(tx_int_ack_i);
		idle(200);
		cmp(rx_valid_o, 1'h0, "off");
		fin("sync off");
		complete_run();
	end
endmodule : spims_shifter_test
`default_nettype wire
